// ### logic/gpr_seg_file.sv
// general purpose and segment register file with address forming
//
// Behaviour
// - each data register reads and writes as 32 bits or its low 16 bits
// - high and low bytes of the low half write independently
// - index, stack and frame registers reachable as 16 or 32 bits
// - string steps use source, destination and count registers
// - stack pointer adjusts itself on push and pop
// - six 16-bit segment registers: code, stack and four data
// - real and v86 linear address is segment times 16 plus offset
// - real or unpaged v86 address is physical; paged v86 translates
// - protected selector splits into index, table bit and privilege
// - descriptor is eight bytes holding base, limit and access rights
// - table bit 0 picks global table, 1 picks local table
// - privilege 0 is most privileged, 3 least
// - effective privilege is the lower of requested and current
// - protected selector load caches descriptor; no refetch until next load
// - code, stack and string destination segments ignore overrides
// - other data uses data segment unless an override names another
// - reset: code F000 base FFFF0000, others zero, limits FFFF
`timescale 1ns/10ps
`include "gprseg_consts.svh"

module gpr_seg_file (
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic WR_EN,
  input wire gprseg_pkg::gpr_idx_t WR_IDX,
  input wire gprseg_pkg::view_t WR_VIEW,
  input wire logic [31:0] WR_DATA,
  input wire gprseg_pkg::gpr_idx_t RD_IDX,
  input wire gprseg_pkg::view_t RD_VIEW,
  output logic [31:0] RD_DATA,
  input wire gprseg_pkg::stk_op_t STK_OP,
  input wire logic STK_WIDE,
  input wire logic STR_STEP,
  input wire logic STR_DOWN,
  input wire logic [2:0] STR_SIZE,
  output logic [31:0] STR_SRC,
  output logic [31:0] STR_DST,
  output logic [31:0] STR_CNT,
  input wire logic SEG_LOAD,
  input wire gprseg_pkg::seg_idx_t SEG_IDX,
  input wire logic [15:0] SEG_SEL,
  input wire logic [63:0] SEG_DESC,
  output logic [12:0] FETCH_INDEX,
  output logic FETCH_LOCAL,
  output logic [1:0] FETCH_RPL,
  input wire logic AG_REQ,
  input wire gprseg_pkg::ref_t AG_REF,
  input wire logic AG_OVR_EN,
  input wire gprseg_pkg::seg_idx_t AG_OVR,
  input wire logic [31:0] AG_OFS,
  input wire logic AG_WIDE,
  output logic [31:0] LIN_ADDR,
  output logic [2:0] AG_SEG,
  output logic [1:0] EFF_PL,
  output logic PHYS_DIRECT,
  output logic NEEDS_XLATE
);
  import gprseg_pkg::*;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);

  state_t q;
  state_t n;
  logic prot;
  logic real_like;
  logic paging;
  logic [1:0] current_priv_level;
  logic apb_access;
  logic apb_commit;
  logic apb_gpr;
  logic apb_seg;
  logic apb_hit;

  function automatic logic [31:0] view_read(logic [31:0] w, view_t v);
    case (v)
      VIEW_LOW_BYTE: view_read = {24'h00_0000, w[7:0]};
      VIEW_HIGH_BYTE: view_read = {24'h00_0000, w[15:8]};
      VIEW_WORD: view_read = {16'h0000, w[15:0]};
      default: view_read = w;
    endcase
  endfunction

  assign prot = q.ctrl[`CTRL_PROT];
  assign real_like = !prot || q.ctrl[`CTRL_V86];
  assign paging = q.ctrl[`CTRL_PAGING];
  assign current_priv_level = q.ctrl[`CTRL_CPL_LSB +: 2];
  assign apb_access = PSEL && PENABLE && !q.pready;
  // writes land only at the edge where the master samples pready
  assign apb_commit = PSEL && PENABLE && PWRITE && q.pready && !q.pslverr;
  assign apb_gpr = PADDR[7:5] == 3'h0 && PADDR[1:0] == 2'h0;
  assign apb_seg = PADDR[7:5] == 3'h1 && PADDR[1:0] == 2'h0 &&
                   PADDR[4:2] < 3'h6;
  assign apb_hit = apb_gpr || apb_seg || PADDR == `OFS_CTRL ||
                   PADDR == `OFS_STATUS;

  always_comb begin
    logic [2:0] ridx;
    logic [2:0] widx;
    logic [31:0] sdelta;
    logic [31:0] ofs;
    logic [2:0] seg;
    logic [1:0] requested_priv_level;
    n = q;
    ridx = RD_VIEW inside {VIEW_LOW_BYTE, VIEW_HIGH_BYTE} ?
           {1'b0, RD_IDX[1:0]} : RD_IDX;
    widx = WR_VIEW inside {VIEW_LOW_BYTE, VIEW_HIGH_BYTE} ?
           {1'b0, WR_IDX[1:0]} : WR_IDX;
    sdelta = {29'h0, STR_SIZE};
    ofs = AG_WIDE ? AG_OFS : {16'h0000, AG_OFS[15:0]};
    seg = SEG_DATA;
    requested_priv_level = 2'h0;
    n.rd_data = view_read(q.gpr[ridx], RD_VIEW);
    case (STK_OP)
      STK_PUSH: begin
        if (STK_WIDE) begin
          n.gpr[GPR_SP] = q.gpr[GPR_SP] - 32'h0000_0004;
        end else begin
          n.gpr[GPR_SP][15:0] = q.gpr[GPR_SP][15:0] - 16'h0002;
        end
      end
      STK_POP: begin
        if (STK_WIDE) begin
          n.gpr[GPR_SP] = q.gpr[GPR_SP] + 32'h0000_0004;
        end else begin
          n.gpr[GPR_SP][15:0] = q.gpr[GPR_SP][15:0] + 16'h0002;
        end
      end
      default: begin
      end
    endcase
    if (STR_STEP) begin
      if (STR_DOWN) begin
        n.gpr[GPR_SRC] = q.gpr[GPR_SRC] - sdelta;
        n.gpr[GPR_DST] = q.gpr[GPR_DST] - sdelta;
      end else begin
        n.gpr[GPR_SRC] = q.gpr[GPR_SRC] + sdelta;
        n.gpr[GPR_DST] = q.gpr[GPR_DST] + sdelta;
      end
      n.gpr[GPR_CNT] = q.gpr[GPR_CNT] - 32'h0000_0001;
    end
    // a direct pipeline write wins over the automatic adjustments
    if (WR_EN) begin
      case (WR_VIEW)
        VIEW_LOW_BYTE: n.gpr[widx][7:0] = WR_DATA[7:0];
        VIEW_HIGH_BYTE: n.gpr[widx][15:8] = WR_DATA[7:0];
        VIEW_WORD: n.gpr[widx][15:0] = WR_DATA[15:0];
        default: n.gpr[widx] = WR_DATA;
      endcase
    end
    if (SEG_LOAD) begin
      n.sel[SEG_IDX] = SEG_SEL;
      if (real_like) begin
        n.base[SEG_IDX] = {12'h000, SEG_SEL, 4'h0};
      end else begin
        // descriptor is cached here and not fetched again until reload
        n.base[SEG_IDX] = {SEG_DESC[`DESC_BASE_HI_LSB +: 8],
                           SEG_DESC[`DESC_BASE_LO_LSB +: 24]};
        n.limit[SEG_IDX] = {SEG_DESC[`DESC_LIMIT_HI_LSB +: 4],
                            SEG_DESC[`DESC_LIMIT_LO_LSB +: 16]};
        n.acc[SEG_IDX] = SEG_DESC[`DESC_ACC_LSB +: 8];
        n.fetch_index = SEG_SEL[`SEL_INDEX_LSB +: 13];
        n.fetch_local = SEG_SEL[`SEL_TABLE_BIT];
        n.fetch_rpl = SEG_SEL[`SEL_RPL_LSB +: 2];
      end
    end
    if (AG_REQ) begin
      case (AG_REF)
        REF_CODE: seg = SEG_CODE;
        REF_STACK: seg = SEG_STACK;
        REF_STR_DST: seg = SEG_EXTRA;
        default: seg = AG_OVR_EN ? AG_OVR : SEG_DATA;
      endcase
      if (real_like) begin
        n.lin_addr = {12'h000, q.sel[seg], 4'h0} + ofs;
      end else begin
        n.lin_addr = q.base[seg] + ofs;
      end
      n.xlate = prot && paging;
      n.phys = !(prot && paging);
      n.ag_seg = seg;
      requested_priv_level = q.sel[seg][`SEL_RPL_LSB +: 2];
      // lower value is more privileged
      n.eff_pl = requested_priv_level < current_priv_level ? requested_priv_level : current_priv_level;
    end
    n.pready = apb_access;
    n.pslverr = apb_access && !apb_hit;
    if (apb_access) begin
      if (apb_gpr) begin
        n.prdata = q.gpr[PADDR[4:2]];
      end else if (apb_seg) begin
        n.prdata = {16'h0000, q.sel[PADDR[4:2]]};
      end else if (PADDR == `OFS_CTRL) begin
        n.prdata = {24'h00_0000, q.ctrl};
      end else if (PADDR == `OFS_STATUS) begin
        n.prdata = {24'h00_0000, 1'b0, q.phys, q.xlate, q.ag_seg, q.eff_pl};
      end else begin
        n.prdata = 32'h0000_0000;
      end
    end
    if (apb_commit) begin
      if (apb_gpr) begin
        n.gpr[PADDR[4:2]] = PWDATA;
      end else if (apb_seg) begin
        n.sel[PADDR[4:2]] = PWDATA[15:0];
        n.base[PADDR[4:2]] = {12'h000, PWDATA[15:0], 4'h0};
      end else if (PADDR == `OFS_CTRL) begin
        n.ctrl = PWDATA[7:0];
      end
    end
    n.str_src = n.gpr[GPR_SRC];
    n.str_dst = n.gpr[GPR_DST];
    n.str_cnt = n.gpr[GPR_CNT];
  end

  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      q <= '0;
      q.sel[SEG_CODE] <= `CODE_SEL_RST;
      q.base[SEG_CODE] <= `CODE_BASE_RST;
      q.limit <= {6{`SEG_LIMIT_RST}};
      q.ctrl <= `CTRL_RST;
      q.phys <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign PRDATA = q.prdata;
  assign PREADY = q.pready;
  assign PSLVERR = q.pslverr;
  assign RD_DATA = q.rd_data;
  assign STR_SRC = q.str_src;
  assign STR_DST = q.str_dst;
  assign STR_CNT = q.str_cnt;
  assign FETCH_INDEX = q.fetch_index;
  assign FETCH_LOCAL = q.fetch_local;
  assign FETCH_RPL = q.fetch_rpl;
  assign LIN_ADDR = q.lin_addr;
  assign AG_SEG = q.ag_seg;
  assign EFF_PL = q.eff_pl;
  assign PHYS_DIRECT = q.phys;
  assign NEEDS_XLATE = q.xlate;

  // checks
  logic quiet;
  assign quiet = STK_OP == STK_NONE && !STR_STEP && !apb_commit;

  property p_reset_code;
    disable iff (1'b0)
    !RESET_N |=> q.sel[SEG_CODE] == `CODE_SEL_RST &&
      q.base[SEG_CODE] == `CODE_BASE_RST && q.sel[SEG_DATA] == 16'h0000;
  endproperty
  a_reset_code: assert property (p_reset_code)
    else $error("reset code segment wrong");

  property p_word_upper;
    logic [2:0] i;
    logic [15:0] v;
    (WR_EN && WR_VIEW == VIEW_WORD && quiet, i = WR_IDX,
     v = q.gpr[WR_IDX][31:16]) |=>
      q.gpr[i][31:16] == v && q.gpr[i][15:0] == $past(WR_DATA[15:0]);
  endproperty
  a_word_upper: assert property (p_word_upper)
    else $error("word write disturbed upper half");

  property p_high_byte;
    logic [2:0] i;
    logic [7:0] v;
    (WR_EN && WR_VIEW == VIEW_HIGH_BYTE && quiet, i = {1'b0, WR_IDX[1:0]},
     v = q.gpr[{1'b0, WR_IDX[1:0]}][7:0]) |=>
      q.gpr[i][7:0] == v && q.gpr[i][15:8] == $past(WR_DATA[7:0]);
  endproperty
  a_high_byte: assert property (p_high_byte)
    else $error("high byte write disturbed low byte");

  property p_push;
    logic [31:0] v;
    (STK_OP == STK_PUSH && STK_WIDE && !WR_EN && !apb_commit,
     v = q.gpr[GPR_SP]) |=> q.gpr[GPR_SP] == v - 32'h0000_0004;
  endproperty
  a_push: assert property (p_push)
    else $error("push did not lower stack pointer by four");

  property p_str_count;
    logic [31:0] v;
    (STR_STEP && !WR_EN && !apb_commit, v = q.gpr[GPR_CNT]) |=>
      STR_CNT == v - 32'h0000_0001;
  endproperty
  a_str_count: assert property (p_str_count)
    else $error("string step did not count down");

  property p_prot_load;
    logic [2:0] i;
    logic [63:0] d;
    (SEG_LOAD && !real_like && !apb_commit, i = SEG_IDX, d = SEG_DESC) |=>
      q.base[i] == {d[63:56], d[39:16]} && q.acc[i] == d[47:40] &&
      FETCH_LOCAL == $past(SEG_SEL[2]);
  endproperty
  a_prot_load: assert property (p_prot_load)
    else $error("descriptor not cached on load");

  property p_real_addr;
    logic [31:0] v;
    (AG_REQ && real_like && AG_REF == REF_CODE && !AG_WIDE,
     v = {12'h000, q.sel[SEG_CODE], 4'h0} + {16'h0000, AG_OFS[15:0]}) |=>
      LIN_ADDR == v && AG_SEG == SEG_CODE;
  endproperty
  a_real_addr: assert property (p_real_addr)
    else $error("real mode address wrong");

  property p_no_override;
    AG_REQ && AG_REF == REF_STACK && AG_OVR_EN |=> AG_SEG == SEG_STACK;
  endproperty
  a_no_override: assert property (p_no_override)
    else $error("stack reference took an override");

  property p_override;
    AG_REQ && AG_REF == REF_DATA |=>
      AG_SEG == ($past(AG_OVR_EN) ? $past(AG_OVR) : SEG_DATA);
  endproperty
  a_override: assert property (p_override)
    else $error("data segment choice wrong");

  property p_eff_pl;
    logic [1:0] r;
    logic [1:0] c;
    (AG_REQ && !apb_commit, r = q.sel[AG_REF == REF_CODE ? SEG_CODE :
     AG_REF == REF_STACK ? SEG_STACK : AG_REF == REF_STR_DST ? SEG_EXTRA :
     AG_OVR_EN ? AG_OVR : SEG_DATA][1:0], c = current_priv_level) |=>
      EFF_PL == (r < c ? r : c);
  endproperty
  a_eff_pl: assert property (p_eff_pl)
    else $error("effective privilege wrong");

  property p_direct;
    AG_REQ && !prot |=> PHYS_DIRECT && !NEEDS_XLATE;
  endproperty
  a_direct: assert property (p_direct)
    else $error("real mode address marked for translation");

  c_push: cover property (STK_OP == STK_PUSH ##1 STK_OP == STK_POP);
  c_prot_load: cover property (SEG_LOAD && !real_like);
  c_override: cover property (AG_REQ && AG_REF == REF_DATA && AG_OVR_EN);
  c_apb_write: cover property (apb_commit);

endmodule

// ### inc/gprseg_consts.svh
// register offsets, field positions and reset values of the register file
`ifndef GPRSEG_CONSTS_SVH
`define GPRSEG_CONSTS_SVH

`define OFS_GPR_FIRST 8'h00
`define OFS_SEG_FIRST 8'h20
`define OFS_CTRL 8'h38
`define OFS_STATUS 8'h3C

`define CODE_SEL_RST 16'hF000
`define CODE_BASE_RST 32'hFFFF_0000
`define SEG_LIMIT_RST 20'h0_FFFF
`define CTRL_RST 8'h00

`define CTRL_PROT 0
`define CTRL_V86 1
`define CTRL_PAGING 2
`define CTRL_CPL_LSB 4

`define SEL_RPL_LSB 0
`define SEL_TABLE_BIT 2
`define SEL_INDEX_LSB 3

`define DESC_LIMIT_LO_LSB 0
`define DESC_BASE_LO_LSB 16
`define DESC_ACC_LSB 40
`define DESC_LIMIT_HI_LSB 48
`define DESC_BASE_HI_LSB 56

`define SEG_SHIFT 4

`endif

// ### inc/gprseg_pkg.sv
// types shared by the register file and its users
package gprseg_pkg;

  typedef enum logic [2:0] {
    GPR_ACC = 3'h0, GPR_CNT = 3'h1, GPR_DEXT = 3'h2, GPR_BASE = 3'h3,
    GPR_SP = 3'h4, GPR_FB = 3'h5, GPR_SRC = 3'h6, GPR_DST = 3'h7
  } gpr_idx_t;

  typedef enum logic [2:0] {
    SEG_EXTRA = 3'h0, SEG_CODE = 3'h1, SEG_STACK = 3'h2,
    SEG_DATA = 3'h3, SEG_AUXF = 3'h4, SEG_AUXG = 3'h5
  } seg_idx_t;

  typedef enum logic [1:0] {
    VIEW_LOW_BYTE = 2'h0, VIEW_HIGH_BYTE = 2'h1,
    VIEW_WORD = 2'h2, VIEW_DWORD = 2'h3
  } view_t;

  typedef enum logic [1:0] {
    REF_CODE = 2'h0, REF_STACK = 2'h1, REF_STR_DST = 2'h2, REF_DATA = 2'h3
  } ref_t;

  typedef enum logic [1:0] {
    STK_NONE = 2'h0, STK_PUSH = 2'h1, STK_POP = 2'h2
  } stk_op_t;

  typedef struct packed {
    logic [7:0][31:0] gpr;
    logic [5:0][15:0] sel;
    logic [5:0][31:0] base;
    logic [5:0][19:0] limit;
    logic [5:0][7:0] acc;
    logic [7:0] ctrl;
    logic [31:0] rd_data;
    logic [31:0] lin_addr;
    logic [2:0] ag_seg;
    logic [1:0] eff_pl;
    logic phys;
    logic xlate;
    logic [12:0] fetch_index;
    logic fetch_local;
    logic [1:0] fetch_rpl;
    logic [31:0] str_src;
    logic [31:0] str_dst;
    logic [31:0] str_cnt;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } state_t;

endpackage

// ### bench/pipe_model.sv
// pipeline model: drives the core-side requests of the register file
`timescale 1ns/10ps
module pipe_model (
  input wire logic clk,
  output gprseg_pkg::gpr_idx_t wr_idx,
  output gprseg_pkg::gpr_idx_t rd_idx,
  output gprseg_pkg::view_t wr_view,
  output gprseg_pkg::view_t rd_view,
  output gprseg_pkg::stk_op_t stk_op,
  output gprseg_pkg::seg_idx_t seg_idx,
  output gprseg_pkg::ref_t ag_ref,
  output gprseg_pkg::seg_idx_t ag_ovr,
  output logic wr_en,
  output logic stk_wide,
  output logic str_step,
  output logic str_down,
  output logic seg_load,
  output logic ag_req,
  output logic ag_ovr_en,
  output logic ag_wide,
  output logic [2:0] str_size,
  output logic [15:0] seg_sel,
  output logic [31:0] wr_data,
  output logic [31:0] ag_ofs,
  output logic [63:0] seg_desc
);
  import gprseg_pkg::*;
  initial begin
    {wr_en, stk_wide, str_step, str_down, seg_load, ag_req} = '0;
    {ag_ovr_en, ag_wide, str_size, seg_sel, wr_data, ag_ofs, seg_desc} = '0;
    wr_idx = GPR_ACC;
    rd_idx = GPR_ACC;
    wr_view = VIEW_DWORD;
    rd_view = VIEW_DWORD;
    stk_op = STK_NONE;
    seg_idx = SEG_EXTRA;
    ag_ref = REF_DATA;
    ag_ovr = SEG_DATA;
  end
  task automatic wr(gpr_idx_t i, view_t v, logic [31:0] d, view_t rv);
    @(posedge clk);
    wr_en <= 1'b1;
    wr_idx <= i;
    wr_view <= v;
    wr_data <= d;
    rd_idx <= i;
    rd_view <= rv;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic run(stk_op_t o, logic w, logic s, logic dn, logic [2:0] sz);
    @(posedge clk);
    stk_op <= o;
    stk_wide <= w;
    str_step <= s;
    str_down <= dn;
    str_size <= sz;
    @(posedge clk);
    stk_op <= STK_NONE;
    str_step <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  // descriptor bus is driven with the inverted descriptor right after the load, so a cache miss shows
  task automatic seg(seg_idx_t i, logic [15:0] s, logic [63:0] d);
    @(posedge clk);
    seg_load <= 1'b1;
    seg_idx <= i;
    seg_sel <= s;
    seg_desc <= d;
    @(posedge clk);
    seg_load <= 1'b0;
    seg_desc <= ~d;
    #1;
  endtask
  task automatic ag(ref_t r, logic e, seg_idx_t o, logic [31:0] a, logic w);
    @(posedge clk);
    ag_req <= 1'b1;
    ag_ref <= r;
    ag_ovr_en <= e;
    ag_ovr <= o;
    ag_ofs <= a;
    ag_wide <= w;
    @(posedge clk);
    ag_req <= 1'b0;
    #1;
  endtask
endmodule

// ### bench/tb.sv
// self-checking bench for the register file
`timescale 1ns/10ps
`include "gprseg_consts.svh"
`define CHK(s, e, g) begin n_checks++; if ((g) !== (e)) begin \
  err_count++; $display("mismatch %s exp %h got %h", s, e, g); end end
module tb;
  import gprseg_pkg::*;
  logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q, rd_data, s_src, s_dst, s_cnt, lin;
  logic [12:0] f_idx;
  logic [1:0] f_rpl, epl;
  logic [2:0] ag_seg, str_size;
  logic f_loc, phys, xl, wr_en, stk_wide, str_step, str_down, seg_load;
  logic ag_req, ag_ovr_en, ag_wide;
  logic [15:0] seg_sel;
  logic [31:0] wr_data, ag_ofs;
  logic [63:0] seg_desc;
  gpr_idx_t wr_idx, rd_idx;
  view_t wr_view, rd_view;
  stk_op_t stk_op;
  seg_idx_t seg_idx, ag_ovr;
  ref_t ag_ref;
  int err_count = 0;
  int n_checks = 0;
  gpr_seg_file dut (
    .MCLK(mclk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .WR_EN(wr_en), .WR_IDX(wr_idx),
    .WR_VIEW(wr_view), .WR_DATA(wr_data), .RD_IDX(rd_idx),
    .RD_VIEW(rd_view), .RD_DATA(rd_data), .STK_OP(stk_op),
    .STK_WIDE(stk_wide), .STR_STEP(str_step), .STR_DOWN(str_down),
    .STR_SIZE(str_size), .STR_SRC(s_src), .STR_DST(s_dst), .STR_CNT(s_cnt),
    .SEG_LOAD(seg_load), .SEG_IDX(seg_idx), .SEG_SEL(seg_sel),
    .SEG_DESC(seg_desc), .FETCH_INDEX(f_idx), .FETCH_LOCAL(f_loc),
    .FETCH_RPL(f_rpl), .AG_REQ(ag_req), .AG_REF(ag_ref),
    .AG_OVR_EN(ag_ovr_en), .AG_OVR(ag_ovr), .AG_OFS(ag_ofs),
    .AG_WIDE(ag_wide), .LIN_ADDR(lin), .AG_SEG(ag_seg), .EFF_PL(epl),
    .PHYS_DIRECT(phys), .NEEDS_XLATE(xl)
  );
  pipe_model pm (
    .clk(mclk), .wr_idx(wr_idx), .rd_idx(rd_idx), .wr_view(wr_view),
    .rd_view(rd_view), .stk_op(stk_op), .seg_idx(seg_idx),
    .ag_ref(ag_ref), .ag_ovr(ag_ovr), .wr_en(wr_en), .stk_wide(stk_wide),
    .str_step(str_step), .str_down(str_down), .seg_load(seg_load),
    .ag_req(ag_req), .ag_ovr_en(ag_ovr_en), .ag_wide(ag_wide),
    .str_size(str_size), .seg_sel(seg_sel), .wr_data(wr_data),
    .ag_ofs(ag_ofs), .seg_desc(seg_desc)
  );
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) err_count++;
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic look(logic [31:0] e);
    @(posedge mclk);
    #1;
    `CHK("view", e, rd_data);
  endtask
  task automatic t_reset;
    for (int s = 0; s < 6; s++) begin
      apb(1'b0, 8'(`OFS_SEG_FIRST + 4 * s), 32'h0000_0000);
      `CHK("sel", (s == 1) ? 32'h0000_F000 : 32'h0000_0000, q);
    end
    apb(1'b1, `OFS_CTRL, 32'h0000_0001);
    pm.ag(REF_CODE, 1'b1, SEG_AUXG, 32'h0000_0010, 1'b1);
    `CHK("code base", 32'hFFFF_0010, lin);
    $display("end reset");
  endtask
  task automatic t_views;
    pm.wr(GPR_ACC, VIEW_DWORD, 32'h1122_3344, VIEW_WORD);
    pm.wr(GPR_ACC, VIEW_HIGH_BYTE, 32'h0000_AAAA, VIEW_WORD);
    look(32'h0000_AA44);
    pm.wr(GPR_ACC, VIEW_LOW_BYTE, 32'h0000_5555, VIEW_WORD);
    look(32'h0000_AA55);
    pm.wr(GPR_ACC, VIEW_WORD, 32'hBEEF_7788, VIEW_HIGH_BYTE);
    look(32'h0000_0077);
    apb(1'b0, 8'h00, 32'h0000_0000);
    `CHK("acc", 32'h1122_7788, q);
    pm.wr(GPR_SRC, VIEW_DWORD, 32'hCAFE_0000, VIEW_DWORD);
    pm.wr(GPR_SRC, VIEW_WORD, 32'h0000_1234, VIEW_DWORD);
    look(32'hCAFE_1234);
    $display("end views");
  endtask
  task automatic t_stack;
    logic [31:0] e [4] = '{32'h0001_FFFE, 32'h0001_FFFA, 32'h0001_FFFE,
                           32'h0001_0000};
    apb(1'b1, 8'h10, 32'h0001_0000);
    for (int k = 0; k < 4; k++) begin
      pm.run(k < 2 ? STK_PUSH : STK_POP, k == 1 || k == 2, 1'b0, 1'b0, 3'h0);
      apb(1'b0, 8'h10, 32'h0000_0000);
      `CHK("stack", e[k], q);
    end
    $display("end stack");
  endtask
  task automatic t_string;
    apb(1'b1, 8'h18, 32'h0000_0100);
    apb(1'b1, 8'h1C, 32'h0000_0200);
    apb(1'b1, 8'h04, 32'h0000_0003);
    pm.run(STK_NONE, 1'b0, 1'b1, 1'b0, 3'h4);
    `CHK("up src", 32'h0000_0104, s_src);
    `CHK("up dst", 32'h0000_0204, s_dst);
    `CHK("up cnt", 32'h0000_0002, s_cnt);
    pm.run(STK_NONE, 1'b0, 1'b1, 1'b1, 3'h2);
    `CHK("dn src", 32'h0000_0102, s_src);
    `CHK("dn dst", 32'h0000_0202, s_dst);
    `CHK("dn cnt", 32'h0000_0001, s_cnt);
    $display("end string");
  endtask
  task automatic t_real;
    int es [4] = '{1, 2, 0, 3};
    int x;
    logic [31:0] e;
    apb(1'b1, `OFS_CTRL, 32'h0000_0000);
    for (int s = 0; s < 6; s++)
      apb(1'b1, 8'(`OFS_SEG_FIRST + 4 * s), 32'((s + 1) << 12));
    for (int k = 0; k < 10; k++) begin
      x = k < 4 ? es[k] : k - 4;
      pm.ag(k < 4 ? ref_t'(k) : REF_DATA, k != 3,
            seg_idx_t'(k < 4 ? 5 - k : k - 4), 32'h0009_0234, k == 9);
      `CHK("seg", 3'(x), ag_seg);
      e = 32'((x + 1) << 16) + (k == 9 ? 32'h0009_0234 : 32'h0000_0234);
      `CHK("lin", e, lin);
      `CHK("phys", 2'b01, {xl, phys});
    end
    pm.seg(SEG_AUXF, 16'h0700, 64'hFFFF_FFFF_FFFF_FFFF);
    `CHK("no fetch", 16'h0000, {f_idx, f_loc, f_rpl});
    pm.ag(REF_DATA, 1'b1, SEG_AUXF, 32'h0000_0010, 1'b0);
    `CHK("auxf", 32'h0000_7010, lin);
    apb(1'b1, `OFS_CTRL, 32'h0000_0007);
    pm.ag(REF_DATA, 1'b0, SEG_CODE, 32'h0000_0010, 1'b1);
    `CHK("v86", 34'h2_0004_0010, {xl, phys, lin});
    $display("end real");
  endtask
  task automatic t_prot;
    apb(1'b1, `OFS_CTRL, 32'h0000_0025);
    pm.seg(SEG_DATA, 16'h091D, 64'h120F_9234_5678_FFFF);
    `CHK("sel", 16'h091D, {f_idx, f_loc, f_rpl});
    pm.ag(REF_DATA, 1'b0, SEG_CODE, 32'hFFFF_0100, 1'b0);
    `CHK("base", 32'h1234_5778, lin);
    `CHK("pl", 4'h9, {xl, phys, epl});
    pm.seg(SEG_STACK, 16'h002B, 64'h0000_9200_0000_FFFF);
    `CHK("sel", 16'h002B, {f_idx, f_loc, f_rpl});
    pm.ag(REF_STACK, 1'b1, SEG_DATA, 32'h0000_0040, 1'b1);
    `CHK("base", 32'h0000_0040, lin);
    `CHK("pl", 2'h2, epl);
    apb(1'b0, `OFS_STATUS, 32'h0000_0000);
    `CHK("status", 32'h0000_002A, q);
    pm.ag(REF_DATA, 1'b1, SEG_AUXF, 32'h0000_0004, 1'b1);
    `CHK("cached", 32'h0000_7004, lin);
    $display("end prot");
  endtask
  task automatic t_err;
    apb(1'b1, 8'h40, 32'hFFFF_FFFF);
    `CHK("slverr", 1'b1, err);
    apb(1'b0, 8'h00, 32'h0000_0000);
    `CHK("okay", 1'b0, err);
    $display("end err");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    rst_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_views();
    t_stack();
    t_string();
    t_real();
    t_prot();
    t_err();
    results();
  end
  initial begin
    #500000;
    err_count++;
    results();
  end
endmodule
